//--- rtl/dee_pkg.sv
// Package: register map, field positions and constants for the data EEPROM controller
package dee_pkg;
  localparam logic [31:0] DEE_CSR_OFFSET = 32'h0000_0030;
  localparam logic [31:0] DEE_ARRAY_BASE = 32'h0000_1000;
  localparam int DEE_ARRAY_BYTES = 128;
  localparam int DEE_ROW_BYTES = 32;
  localparam int DEE_CSR_PGM_BIT = 0;
  localparam int DEE_CSR_LAT_BIT = 1;
  localparam logic [7:0] DEE_CSR_RESET = 8'h00;
  localparam int DEE_CLK_MHZ = 125;
  localparam int DEE_PROG_TIME_US = 3;
  localparam int DEE_PROG_CYCLES = DEE_PROG_TIME_US * DEE_CLK_MHZ;
  localparam logic [1:0] DEE_HTRANS_NONSEQ = 2'b10;
  typedef enum logic [1:0] {DEE_IDLE, DEE_PROG, DEE_ERASE, DEE_STOP} dee_state_t;
  typedef struct packed {
    logic lat;
    logic pgm;
  } dee_csr_t;
endpackage : dee_pkg

//--- rtl/dee_ctrl.sv
// Data EEPROM write controller with AHB-Lite register and array access
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module dee_ctrl import dee_pkg::*; #(
  parameter int PROG_CYCLES = DEE_PROG_CYCLES,
  parameter int ARRAY_BYTES = DEE_ARRAY_BYTES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hrdata_en,
  output logic hreadyout,
  output logic hresp,
  input wire logic wait_req,
  input wire logic halt_req,
  input wire logic readout_protect,
  input wire logic protect_remove,
  output logic wait_ack,
  output logic halted,
  output logic prog_busy
);
  localparam int AW = $clog2(ARRAY_BYTES);
  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam int NROWS = ARRAY_BYTES / DEE_ROW_BYTES;

  initial begin
    if (PROG_CYCLES < 1 || ARRAY_BYTES < DEE_ROW_BYTES || ARRAY_BYTES % DEE_ROW_BYTES != 0)
      $error("dee_ctrl: unsupported parameters");
  end

  logic [7:0] mem [ARRAY_BYTES];
  logic [7:0] latch_r [DEE_ROW_BYTES];
  logic [DEE_ROW_BYTES-1:0] loaded_r;
  logic [AW-6:0] row_r;
  dee_csr_t csr_r;
  dee_state_t state_r;
  logic [CW-1:0] cnt_r;
  logic [AW-1:0] erase_idx_r;
  logic lat_q_r;

  // Data-phase capture of the address phase
  logic dp_valid_r, dp_write_r, dp_csr_r, dp_arr_r;
  logic [AW-1:0] dp_addr_r;

  logic take;
  logic sel_csr, sel_arr;
  logic prog_done;
  logic csr_wr, arr_wr;
  logic lat_fall;

  assign take = hsel && hready && htrans == DEE_HTRANS_NONSEQ;
  assign sel_csr = haddr[31:2] == DEE_CSR_OFFSET[31:2];
  assign sel_arr = haddr >= DEE_ARRAY_BASE && haddr < DEE_ARRAY_BASE + 32'(ARRAY_BYTES);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_csr_r <= 1'b0;
      dp_arr_r <= 1'b0;
      dp_addr_r <= '0;
    end else if (hready) begin
      dp_valid_r <= take;
      dp_write_r <= hwrite;
      dp_csr_r <= take && sel_csr;
      dp_arr_r <= take && sel_arr;
      dp_addr_r <= haddr[AW-1:0];
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign csr_wr = dp_valid_r && dp_write_r && dp_csr_r;
  // Halt abandons programming, and bus writes to the array are dropped too
  assign arr_wr = dp_valid_r && dp_write_r && dp_arr_r && csr_r.lat && !csr_r.pgm
                  && !readout_protect && !halt_req;
  assign prog_done = state_r == DEE_PROG && cnt_r == CW'(PROG_CYCLES - 1);

  // Control/status register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csr_r <= dee_csr_t'(DEE_CSR_RESET[1:0]);
    end else if (prog_done || halt_req && csr_r.pgm) begin
      csr_r.pgm <= 1'b0;
      csr_r.lat <= 1'b0;
    end else if (csr_wr) begin
      // Hardware end-of-cycle above wins over a same-cycle write
      csr_r.pgm <= hwdata[DEE_CSR_PGM_BIT] && !readout_protect;
      if (hwdata[DEE_CSR_LAT_BIT] || !csr_r.pgm)
        csr_r.lat <= hwdata[DEE_CSR_LAT_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      lat_q_r <= 1'b0;
    else
      lat_q_r <= csr_r.lat;
  end
  assign lat_fall = lat_q_r && !csr_r.lat;

  // Row latches; cleared only by reset, cycle end or latch-mode falling edge
  genvar gi;
  generate
    for (gi = 0; gi < DEE_ROW_BYTES; gi++) begin : g_latch
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          latch_r[gi] <= 8'hff;
          loaded_r[gi] <= 1'b0;
        end else if (prog_done || lat_fall) begin
          latch_r[gi] <= 8'hff;
          loaded_r[gi] <= 1'b0;
        end else if (arr_wr && dp_addr_r[4:0] == 5'(gi)) begin
          latch_r[gi] <= loaded_r[gi] ? latch_r[gi] & hwdata[7:0] : hwdata[7:0];
          loaded_r[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      row_r <= '0;
    else if (arr_wr)
      row_r <= dp_addr_r[AW-1:5];
  end

  // Sequencer: programming, erase on protection removal, halt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= DEE_IDLE;
      cnt_r <= '0;
      erase_idx_r <= '0;
    end else begin
      case (state_r)
        DEE_IDLE: begin
          cnt_r <= '0;
          if (halt_req)
            state_r <= DEE_STOP;
          else if (protect_remove) begin
            erase_idx_r <= '0;
            state_r <= DEE_ERASE;
          end else if (csr_r.pgm)
            state_r <= DEE_PROG;
        end
        DEE_PROG: begin
          cnt_r <= cnt_r + CW'(1);
          if (halt_req)
            state_r <= DEE_STOP;
          else if (prog_done || !csr_r.pgm)
            state_r <= DEE_IDLE;
        end
        DEE_ERASE: begin
          erase_idx_r <= erase_idx_r + AW'(1);
          if (erase_idx_r == AW'(ARRAY_BYTES - 1))
            state_r <= DEE_IDLE;
        end
        DEE_STOP: begin
          if (!halt_req)
            state_r <= DEE_IDLE;
        end
        default: state_r <= DEE_IDLE;
      endcase
    end
  end

  // Array cells; a reset or halt mid-cycle simply loses the update
  always_ff @(posedge hclk) begin
    if (state_r == DEE_ERASE)
      mem[erase_idx_r] <= 8'hff;
    else if (prog_done && !halt_req) begin
      for (int i = 0; i < DEE_ROW_BYTES; i++) begin
        if (loaded_r[i])
          mem[{row_r, 5'(i)}] <= latch_r[i];
      end
    end
  end

  // Read data: latches never reach hrdata
  always_comb begin
    hrdata = 32'h0000_0000;
    hrdata_en = 1'b0;
    if (dp_valid_r && !dp_write_r) begin
      if (dp_csr_r) begin
        hrdata = {30'h0, csr_r.lat, csr_r.pgm};
        hrdata_en = 1'b1;
      end else if (dp_arr_r && !csr_r.lat && !readout_protect) begin
        hrdata = {24'h0, mem[dp_addr_r]};
        hrdata_en = 1'b1;
      end
      // Latch mode set: bus left undriven
    end
  end

  assign wait_ack = wait_req && state_r == DEE_IDLE && !csr_r.pgm;
  assign halted = state_r == DEE_STOP;
  assign prog_busy = csr_r.pgm;

  // Independent cycle count so the length checks do not trust cnt_r
  logic [CW:0] len_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      len_r <= '0;
    else if (state_r == DEE_PROG)
      len_r <= len_r + (CW+1)'(1);
    else
      len_r <= '0;
  end

  a_done_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    prog_done && !halt_req |=> !csr_r.pgm && !csr_r.lat)
    else $error("cycle end did not clear control bits");
  a_cycle_len: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == DEE_PROG && csr_r.pgm && !halt_req && !csr_wr
    && len_r < (CW+1)'(PROG_CYCLES - 1) |=> csr_r.pgm)
    else $error("programming cycle ended early");
  a_cnt_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == DEE_PROG |-> cnt_r < CW'(PROG_CYCLES))
    else $error("cycle counter overran");
  a_no_read_lat: assert property (@(posedge hclk) disable iff (!hresetn)
    dp_valid_r && !dp_write_r && dp_arr_r && csr_r.lat |-> !hrdata_en)
    else $error("array read driven in latch mode");
  a_csr_upper: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata_en && dp_csr_r |-> hrdata[31:2] == 30'h0)
    else $error("reserved bits not zero");
  a_ignore_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    dp_valid_r && dp_write_r && dp_arr_r && !csr_r.lat && !prog_done && !lat_fall
    |=> $stable(loaded_r))
    else $error("write captured in read mode");
  a_lat_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    csr_wr && !hwdata[DEE_CSR_LAT_BIT] && csr_r.pgm && csr_r.lat && !prog_done
    && !halt_req |=> csr_r.lat)
    else $error("latch-mode cleared while programming");
  a_lat_fall_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    lat_fall |=> loaded_r == '0)
    else $error("latches kept after latch-mode fall");
  a_halt_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    halt_req && state_r == DEE_PROG |=> state_r == DEE_STOP && !csr_r.pgm)
    else $error("halt did not abandon programming");
  a_wait_busy: assert property (@(posedge hclk) disable iff (!hresetn)
    csr_r.pgm |-> !wait_ack)
    else $error("wait granted while programming");

  // Sequencer, erase and cell update
  a_cycle_end: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == DEE_PROG && csr_r.pgm && !halt_req && len_r == (CW+1)'(PROG_CYCLES - 1)
    |=> !csr_r.pgm && state_r == DEE_IDLE)
    else $error("programming cycle did not end on time");
  a_cnt_step: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == DEE_PROG && csr_r.pgm && !halt_req && !prog_done
    |=> cnt_r == $past(cnt_r) + CW'(1))
    else $error("cycle counter did not advance");
  a_pgm_start: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == DEE_IDLE && csr_r.pgm && !halt_req && !protect_remove
    |=> state_r == DEE_PROG)
    else $error("programming did not start");
  a_pgm_busy: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == DEE_PROG && csr_r.pgm && !halt_req && !prog_done && !csr_wr
    |=> csr_r.pgm)
    else $error("program-start dropped while running");
  a_abort_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == DEE_PROG && !csr_r.pgm && !halt_req
    |=> state_r == DEE_IDLE)
    else $error("software abort not honoured");
  a_halt_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    halt_req && state_r == DEE_IDLE
    |=> state_r == DEE_STOP)
    else $error("halt not entered from idle");
  a_stop_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == DEE_STOP && halt_req
    |=> state_r == DEE_STOP)
    else $error("left halt while still requested");
  a_wait_after: assert property (@(posedge hclk) disable iff (!hresetn)
    prog_done && !halt_req ##1 wait_req
    |-> wait_ack)
    else $error("wait not granted after cycle end");
  a_erase_start: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == DEE_IDLE && protect_remove && !halt_req
    |=> state_r == DEE_ERASE)
    else $error("erase did not start");
  a_erase_len: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == DEE_ERASE && erase_idx_r == AW'(ARRAY_BYTES - 1)
    |=> state_r == DEE_IDLE)
    else $error("erase did not end at last byte");
  a_erase_cell: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == DEE_ERASE
    |=> mem[$past(erase_idx_r)] == 8'hff)
    else $error("erased cell not blank");
  a_cell_write: assert property (@(posedge hclk) disable iff (!hresetn)
    prog_done && !halt_req && loaded_r[5]
    |=> mem[{$past(row_r), 5'(5)}] == $past(latch_r[5]))
    else $error("loaded latch not programmed");

  // Bus side and latches
  a_rd_mode_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    dp_valid_r && !dp_write_r && dp_arr_r && !csr_r.lat && !readout_protect
    |-> hrdata_en)
    else $error("read-mode array read not driven");
  a_prot_no_read: assert property (@(posedge hclk) disable iff (!hresetn)
    dp_valid_r && !dp_write_r && dp_arr_r && readout_protect
    |-> !hrdata_en)
    else $error("protected array read driven");
  a_unmapped_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    dp_valid_r && !dp_write_r && !dp_csr_r && !dp_arr_r
    |-> !hrdata_en && hrdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_prot_no_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    dp_valid_r && dp_write_r && dp_arr_r && readout_protect && !prog_done && !lat_fall
    |=> $stable(loaded_r))
    else $error("protected write captured");
  a_latch_load: assert property (@(posedge hclk) disable iff (!hresetn)
    arr_wr && !prog_done && !lat_fall
    |=> loaded_r[$past(dp_addr_r[4:0])])
    else $error("write-mode byte not latched");
  a_and_merge: assert property (@(posedge hclk) disable iff (!hresetn)
    arr_wr && loaded_r[dp_addr_r[4:0]] && !prog_done && !lat_fall
    |=> latch_r[$past(dp_addr_r[4:0])]
        == ($past(latch_r[dp_addr_r[4:0]]) & $past(hwdata[7:0])))
    else $error("repeated write not merged by AND");
  a_row_take: assert property (@(posedge hclk) disable iff (!hresetn)
    arr_wr
    |=> row_r == $past(dp_addr_r[AW-1:5]))
    else $error("row not taken from last write");
  a_done_clr_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    prog_done
    |=> loaded_r == '0)
    else $error("latches kept after cycle end");
  a_latch_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    !prog_done && !lat_fall && !arr_wr
    |=> $stable(loaded_r))
    else $error("latches changed without cause");
  a_arr_halt_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    dp_valid_r && dp_write_r && dp_arr_r && halt_req && !prog_done && !lat_fall
    |=> $stable(loaded_r))
    else $error("write captured during halt");
  a_pgm_locked_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    dp_valid_r && dp_write_r && dp_arr_r && csr_r.pgm && !prog_done && !lat_fall
    |=> $stable(loaded_r))
    else $error("write captured while programming");
  a_lat_set: assert property (@(posedge hclk) disable iff (!hresetn)
    csr_wr && hwdata[DEE_CSR_LAT_BIT] && !prog_done && !(halt_req && csr_r.pgm)
    |=> csr_r.lat)
    else $error("latch-mode not set by write");
  a_prot_no_pgm: assert property (@(posedge hclk) disable iff (!hresetn)
    csr_wr && readout_protect && !csr_r.pgm
    |=> !csr_r.pgm)
    else $error("programming started under protection");
  c_prog: cover property (@(posedge hclk) disable iff (!hresetn) prog_done);
  c_and: cover property (@(posedge hclk) disable iff (!hresetn)
    arr_wr && loaded_r[dp_addr_r[4:0]]);
  c_halt: cover property (@(posedge hclk) disable iff (!hresetn)
    halt_req && state_r == DEE_PROG);
  c_wait: cover property (@(posedge hclk) disable iff (!hresetn) wait_ack);
  c_erase: cover property (@(posedge hclk) disable iff (!hresetn)
    state_r == DEE_ERASE);
endmodule : dee_ctrl

//--- verif/dee_cpu_model.sv
// CPU-side bus master model issuing single AHB-Lite transfers
`timescale 1ns/1ps
module dee_cpu_model import dee_pkg::*; (
  input wire logic hclk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hrdata_en
);
  logic [7:0] rd_q;
  logic en_q;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
  end
  // Sample on the edge so later state changes cannot leak in
  always @(posedge hclk) begin
    rd_q <= hrdata[7:0];
    en_q <= hrdata_en;
  end
  task xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic en);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= DEE_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    // Stale data lane flips so an early capture shows up
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    #1;
    q = rd_q;
    en = en_q;
  endtask : xfer
endmodule : dee_cpu_model

//--- verif/tb.sv
// Self-checking bench for the data EEPROM write controller
`timescale 1ns/1ps
module tb import dee_pkg::*; ();
  localparam int PC = 40;
  localparam logic [31:0] C = DEE_CSR_OFFSET;
  localparam logic [31:0] B = DEE_ARRAY_BASE;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic wait_req = 1'b0;
  logic halt_req = 1'b0;
  logic readout_protect = 1'b0;
  logic protect_remove = 1'b0;
  logic hsel, hwrite, hrdata_en, hreadyout, hresp, wait_ack, halted, prog_busy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] q;
  logic en;
  int n_errors = 0;
  int tests_run = 0;
  int k;
  always #4 hclk = ~hclk;
  dee_ctrl #(.PROG_CYCLES(PC), .ARRAY_BYTES(DEE_ARRAY_BYTES)) u_dee_ctrl (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hrdata_en(hrdata_en), .hreadyout(hreadyout), .hresp(hresp), .wait_req(wait_req),
    .halt_req(halt_req), .readout_protect(readout_protect), .protect_remove(protect_remove),
    .wait_ack(wait_ack), .halted(halted), .prog_busy(prog_busy));
  dee_cpu_model u_cpu (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hrdata_en(hrdata_en));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [31:0] a, input logic [7:0] d);
    u_cpu.xfer(1'b1, a, d, q, en);
  endtask : wr
  task rd(input logic [31:0] a);
    u_cpu.xfer(1'b0, a, 8'h00, q, en);
  endtask : rd
  // Bounded so a stuck cycle cannot hang the run
  task idle_wait;
    for (k = 0; k < 2 * PC && prog_busy !== 1'b0; k++) begin
      @(posedge hclk);
      #1;
    end
  endtask : idle_wait
  task ticks(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : ticks
  task t_csr;
    rd(C);
    chk("csr_rst", 32'h00, q);
    wr(C, 8'hfc);
    rd(C);
    chk("csr_rsvd", 32'h00, q);
    rd(32'h40);
    chk("unmapped_en", 32'h0, en);
    chk("hresp_okay", 32'h0, hresp);
    chk("hready_hi", 32'h1, hreadyout);
  endtask : t_csr
  task t_prog;
    wr(C, 8'h02);
    rd(B + 32'h5);
    chk("lat_rd_en", 32'h0, en);
    wr(B + 32'h5, 8'ha5);
    wr(B + 32'h5, 8'h3c);
    wr(B + 32'h1f, 8'h77);
    wr(C, 8'h03);
    rd(C);
    chk("pgm_run", 32'h03, q);
    wr(C, 8'h01);
    rd(C);
    chk("lat_hold", 32'h03, q);
    idle_wait();
    rd(C);
    chk("csr_end", 32'h00, q);
    rd(B + 32'h5);
    chk("and_byte", 32'h24, q);
    rd(B + 32'h1f);
    chk("top_byte", 32'h77, q);
  endtask : t_prog
  task t_time;
    wr(C, 8'h02);
    wr(B + 32'h25, 8'h0f);
    wr(C, 8'h03);
    idle_wait();
    chk("cyc_len", 32'h1, k >= PC - 1 && k <= PC + 3);
    rd(B + 32'h25);
    chk("row1", 32'h0f, q);
    rd(B + 32'h5);
    chk("row0_kept", 32'h24, q);
  endtask : t_time
  task t_drop;
    wr(B + 32'h5, 8'h00);
    wr(C, 8'h02);
    wr(B + 32'h5, 8'h00);
    wr(C, 8'h00);
    wr(C, 8'h03);
    idle_wait();
    rd(B + 32'h5);
    chk("drop_kept", 32'h24, q);
  endtask : t_drop
  task t_prot;
    @(posedge hclk);
    readout_protect <= 1'b1;
    rd(B + 32'h5);
    chk("prot_rd_en", 32'h0, en);
    wr(C, 8'h02);
    wr(B + 32'h5, 8'h00);
    @(posedge hclk);
    readout_protect <= 1'b0;
    wr(C, 8'h03);
    idle_wait();
    rd(B + 32'h5);
    chk("prot_kept", 32'h24, q);
  endtask : t_prot
  task t_wait;
    @(posedge hclk);
    wait_req <= 1'b1;
    ticks(1);
    chk("ack_idle", 32'h1, wait_ack);
    wr(C, 8'h02);
    wr(B + 32'h7, 8'h5a);
    wr(C, 8'h03);
    chk("ack_busy", 32'h0, wait_ack);
    idle_wait();
    ticks(1);
    chk("ack_done", 32'h1, wait_ack);
    wait_req <= 1'b0;
    rd(B + 32'h7);
    chk("wait_byte", 32'h5a, q);
  endtask : t_wait
  task t_halt;
    wr(C, 8'h02);
    wr(B + 32'h48, 8'h00);
    wr(C, 8'h03);
    @(posedge hclk);
    halt_req <= 1'b1;
    ticks(2);
    chk("halted", 32'h1, halted);
    chk("halt_busy", 32'h0, prog_busy);
    @(posedge hclk);
    halt_req <= 1'b0;
    rd(C);
    chk("halt_csr", 32'h00, q);
  endtask : t_halt
  task t_erase;
    @(posedge hclk);
    protect_remove <= 1'b1;
    @(posedge hclk);
    protect_remove <= 1'b0;
    // Erase walks all 128 bytes, one per cycle
    ticks(140);
    rd(B + 32'h5);
    chk("erase_lo", 32'hff, q);
    rd(B + 32'h7f);
    chk("erase_hi", 32'hff, q);
  endtask : t_erase
  task finish_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_csr();
    t_prog();
    t_time();
    t_drop();
    t_prot();
    t_wait();
    t_halt();
    t_erase();
    finish_test();
  end
endmodule : tb
